// >>> hw/chgc5_regs.v
// charger control five, reserved and temperature control registers
// assumes an external i2c target decodes transactions into single-cycle
// read and write strobes with an 8-bit register address, all on core_clk_i
// rst_n_i stands for power-on reset and is sampled on the clock
// a register reset command restores every field to its default, a watchdog expiry only some
// reads see the value left after this cycle's reset, watchdog and write
//
// Contract
// - while fitted bit is 0, ocp enable, force-off, driver ctrl stay zero
// - fitted bit 1 makes the three ship-switch fields writable and active
// - current monitor pin driven only while its enable is 1; default 0
// - otg discharge limit codes 3A,4A,5A,disable; default 2, watchdog reset
// - internal input limit applied while enable is 1; default 1
// - pin input limit applied while enable 1; default 1, not by watchdog
// - discharge over-current protection on while enable is 1; default 0
// - register 0x15 is reserved, read-only, reads zero
// - thermal regulation code selects 60..120 C; default 3
// - thermal shutdown code selects 150,130,120,85 C; default 0
// - bus pull-down connected while enable 1; register reset only
// - source one pull-down connected while enable 1; register reset only
// - source two pull-down connected while enable 1; register reset only
// - temperature register resets to 0xc0, bit 0 reads zero
// - control five at 0x14 resets to 0x16, bit 6 reads zero
`timescale 1ns/10ps
`include "chgc5_consts.vh"

module chgc5_regs (
   // clock and reset
   input  wire       core_clk_i,
   input  wire       rst_n_i,
   // register access from the i2c target
   input  wire       wr_en_i,
   input  wire       rd_en_i,
   input  wire [7:0] addr_i,
   input  wire [7:0] wdata_i,
   output reg  [7:0] rdata_o,
   output reg        rvalid_o,
   // reset events
   input  wire       wdog_expire_i,
   input  wire       reg_reset_i,
   // ship switch controls
   input  wire       force_off_wr_i,
   input  wire       force_off_i,
   input  wire [1:0] drv_ctrl_wr_i,
   output reg        ship_switch_fitted_o,
   output reg        ship_switch_force_off_o,
   output reg  [1:0] ship_driver_ctrl_o,
   // charger settings
   output reg        batt_current_out_en_o,
   output reg  [1:0] otg_discharge_limit_o,
   output reg        internal_input_limit_en_o,
   output reg        pin_input_limit_en_o,
   output reg        batt_discharge_ocp_en_o,
   output reg  [1:0] thermal_reg_threshold_o,
   output reg  [1:0] thermal_shutdown_threshold_o,
   output reg        bus_pulldown_en_o,
   output reg        source1_pulldown_en_o,
   output reg        source2_pulldown_en_o
);

   // reset words, taken apart by field so each default is written once
   localparam [7:0] CTRL5_RST = `CHGC5_CTRL5_RST;
   localparam [7:0] TEMP_RST  = `CHGC5_TEMP_RST;

   reg  [7:0] ctrl5_d;
   reg  [7:0] temp_d;
   reg        force_off_d;
   reg  [1:0] drv_d;
   reg  [7:0] rdata_d;

   // take masked bits from new value, keep the rest from old
   function [7:0] chgc5_merge;
      input [7:0] old_v;
      input [7:0] new_v;
      input [7:0] mask;
      begin
         chgc5_merge = (old_v & ~mask) | (new_v & mask);
      end
   endfunction

   // one offset decode shared by both write strobes
   function chgc5_hit;
      input [7:0] addr;
      input [7:0] offset;
      begin
         chgc5_hit = (addr == offset);
      end
   endfunction

   // write strobes, one per writable register
   wire       wr_ctrl5 = wr_en_i && chgc5_hit(addr_i, `CHGC5_ADDR_CTRL5);
   wire       wr_temp  = wr_en_i && chgc5_hit(addr_i, `CHGC5_ADDR_TEMP);

   wire [7:0] ctrl5_q = {ship_switch_fitted_o, 1'b0,
                         batt_current_out_en_o, otg_discharge_limit_o,
                         internal_input_limit_en_o, pin_input_limit_en_o,
                         batt_discharge_ocp_en_o};
   wire [7:0] temp_q  = {thermal_reg_threshold_o,
                         thermal_shutdown_threshold_o, bus_pulldown_en_o,
                         source1_pulldown_en_o, source2_pulldown_en_o,
                         1'b0};

   // watchdog restores only its own fields; a write in the same cycle is
   // applied after it so software intent survives the expiry
   always @* begin
      ctrl5_d = ctrl5_q;
      temp_d  = temp_q;
      if (reg_reset_i) begin
         ctrl5_d = CTRL5_RST;
         temp_d  = TEMP_RST;
      end else begin
         if (wdog_expire_i) begin
            ctrl5_d = chgc5_merge(ctrl5_d, CTRL5_RST,
                                  `CHGC5_CTRL5_WD_MASK);
            temp_d  = chgc5_merge(temp_d, TEMP_RST,
                                  `CHGC5_TEMP_WD_MASK);
         end
         if (wr_ctrl5)
            ctrl5_d = chgc5_merge(ctrl5_d, wdata_i,
                                  `CHGC5_CTRL5_WR_MASK);
         if (wr_temp)
            temp_d = chgc5_merge(temp_d, wdata_i,
                                 `CHGC5_TEMP_WR_MASK);
      end
      // the fitted value of this very write decides the lock, so a host
      // can never see the over-current enable set while unfitted
      if (!ctrl5_d[`CHGC5_FITTED_BIT])
         ctrl5_d[`CHGC5_OCP_BIT] = 1'b0;
   end

   // force-off and driver control live in another register; they pass
   // through here only so the fitted bit can hold them at zero
   always @* begin
      force_off_d = ship_switch_force_off_o;
      drv_d       = ship_driver_ctrl_o;
      if (reg_reset_i) begin
         force_off_d = 1'b0;
         drv_d       = `CHGC5_DRV_OFF;
      end else begin
         if (force_off_wr_i)
            force_off_d = force_off_i;
         drv_d = drv_ctrl_wr_i;
      end
      if (!ctrl5_d[`CHGC5_FITTED_BIT]) begin
         force_off_d = 1'b0;
         drv_d       = `CHGC5_DRV_OFF;
      end
   end

   // reserved register and unmapped offsets read zero; the mux looks at
   // the next values so a read beside a write returns what was written
   always @* begin
      case (addr_i)
         `CHGC5_ADDR_CTRL5: rdata_d = ctrl5_d;
         `CHGC5_ADDR_TEMP:  rdata_d = temp_d;
         `CHGC5_ADDR_RSVD:  rdata_d = `CHGC5_RSVD_VAL;
         default:           rdata_d = `CHGC5_RSVD_VAL;
      endcase
   end

   // charger control five fields; the readback word is rebuilt from these
   // flops, so no shadow copy can drift from what the pins show
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ship_switch_fitted_o      <= CTRL5_RST[`CHGC5_FITTED_BIT];
         batt_current_out_en_o     <= CTRL5_RST[`CHGC5_CUR_OUT_BIT];
         otg_discharge_limit_o     <=
            CTRL5_RST[`CHGC5_OTG_LIM_HI:`CHGC5_OTG_LIM_LO];
         internal_input_limit_en_o <= CTRL5_RST[`CHGC5_INT_LIM_BIT];
         pin_input_limit_en_o      <= CTRL5_RST[`CHGC5_PIN_LIM_BIT];
         batt_discharge_ocp_en_o   <= CTRL5_RST[`CHGC5_OCP_BIT];
      end else begin
         ship_switch_fitted_o      <= ctrl5_d[`CHGC5_FITTED_BIT];
         batt_current_out_en_o     <= ctrl5_d[`CHGC5_CUR_OUT_BIT];
         otg_discharge_limit_o     <=
            ctrl5_d[`CHGC5_OTG_LIM_HI:`CHGC5_OTG_LIM_LO];
         internal_input_limit_en_o <= ctrl5_d[`CHGC5_INT_LIM_BIT];
         pin_input_limit_en_o      <= ctrl5_d[`CHGC5_PIN_LIM_BIT];
         batt_discharge_ocp_en_o   <= ctrl5_d[`CHGC5_OCP_BIT];
      end
   end

   // temperature control fields; the pull-down enables ride out a watchdog
   // and only a register reset or power-on clears them
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         thermal_reg_threshold_o      <=
            TEMP_RST[`CHGC5_THERMAL_REG_THRESHOLD_HI:`CHGC5_THERMAL_REG_THRESHOLD_LO];
         thermal_shutdown_threshold_o <=
            TEMP_RST[`CHGC5_THERMAL_SHUTDOWN_THRESHOLD_HI:`CHGC5_THERMAL_SHUTDOWN_THRESHOLD_LO];
         bus_pulldown_en_o            <= TEMP_RST[`CHGC5_BUS_PD_BIT];
         source1_pulldown_en_o        <= TEMP_RST[`CHGC5_SRC1_PD_BIT];
         source2_pulldown_en_o        <= TEMP_RST[`CHGC5_SRC2_PD_BIT];
      end else begin
         thermal_reg_threshold_o   <=
            temp_d[`CHGC5_THERMAL_REG_THRESHOLD_HI:`CHGC5_THERMAL_REG_THRESHOLD_LO];
         thermal_shutdown_threshold_o <=
            temp_d[`CHGC5_THERMAL_SHUTDOWN_THRESHOLD_HI:`CHGC5_THERMAL_SHUTDOWN_THRESHOLD_LO];
         bus_pulldown_en_o         <= temp_d[`CHGC5_BUS_PD_BIT];
         source1_pulldown_en_o     <= temp_d[`CHGC5_SRC1_PD_BIT];
         source2_pulldown_en_o     <= temp_d[`CHGC5_SRC2_PD_BIT];
      end
   end

   // ship controls and the read port
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ship_switch_force_off_o <= 1'b0;
         ship_driver_ctrl_o      <= `CHGC5_DRV_OFF;
         rdata_o                 <= `CHGC5_RSVD_VAL;
         rvalid_o                <= 1'b0;
      end else begin
         ship_switch_force_off_o <= force_off_d;
         ship_driver_ctrl_o      <= drv_d;
         rdata_o                 <= rd_en_i ? rdata_d : rdata_o;
         rvalid_o                <= rd_en_i;
      end
   end

endmodule // chgc5_regs

// >>> shared/chgc5_consts.vh
// register offsets, field positions and reset values of the charger
// control five, reserved and temperature control registers
`ifndef CHGC5_CONSTS_VH
`define CHGC5_CONSTS_VH

`define CHGC5_ADDR_CTRL5      8'h14
`define CHGC5_ADDR_RSVD       8'h15
`define CHGC5_ADDR_TEMP       8'h16

`define CHGC5_CTRL5_RST       8'h16
`define CHGC5_RSVD_VAL        8'h00
`define CHGC5_TEMP_RST        8'hc0

// charger control five fields
`define CHGC5_FITTED_BIT      7
`define CHGC5_CUR_OUT_BIT     5
`define CHGC5_OTG_LIM_HI      4
`define CHGC5_OTG_LIM_LO      3
`define CHGC5_INT_LIM_BIT     2
`define CHGC5_PIN_LIM_BIT     1
`define CHGC5_OCP_BIT         0

// watchdog-resettable bits and writable bits of charger control five
`define CHGC5_CTRL5_WD_MASK   8'h3d
`define CHGC5_CTRL5_WR_MASK   8'hbf

// temperature control fields
`define CHGC5_THERMAL_REG_THRESHOLD_HI         7
`define CHGC5_THERMAL_REG_THRESHOLD_LO         6
`define CHGC5_THERMAL_SHUTDOWN_THRESHOLD_HI        5
`define CHGC5_THERMAL_SHUTDOWN_THRESHOLD_LO        4
`define CHGC5_BUS_PD_BIT      3
`define CHGC5_SRC1_PD_BIT     2
`define CHGC5_SRC2_PD_BIT     1
`define CHGC5_TEMP_WD_MASK    8'hf0
`define CHGC5_TEMP_WR_MASK    8'hfe

// ship driver control: two bits, and force-off bit
`define CHGC5_DRV_OFF         2'h0

`endif

// >>> bench/chgc5_regs_assertions.sv
// checker for the charger control five and temperature registers
// sees only the ports of chgc5_regs; bound in at the foot of this file
`timescale 1ns/10ps
module chgc5_regs_chk (
   input wire       core_clk_i, rst_n_i, wr_en_i, rd_en_i, rvalid_o,
   input wire       wdog_expire_i, reg_reset_i, ship_switch_fitted_o,
   input wire       ship_switch_force_off_o, batt_current_out_en_o,
   input wire       internal_input_limit_en_o, pin_input_limit_en_o,
   input wire       batt_discharge_ocp_en_o, bus_pulldown_en_o,
   input wire [7:0] addr_i, wdata_i, rdata_o,
   input wire [1:0] ship_driver_ctrl_o, otg_discharge_limit_o,
   input wire [1:0] thermal_reg_threshold_o, thermal_shutdown_threshold_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_rd(a); rd_en_i && addr_i == a; endsequence
   // a write wins over a watchdog in the same cycle, so leave those out
   sequence s_wd; wdog_expire_i && !reg_reset_i && !wr_en_i; endsequence
   sequence s_wr14; wr_en_i && addr_i == 8'h14 && !reg_reset_i; endsequence
   a_ocp_locked: assert property (!ship_switch_fitted_o |->
      !batt_discharge_ocp_en_o) else $error("ocp enable while unfitted");
   a_ship_locked: assert property (!ship_switch_fitted_o |->
      !ship_switch_force_off_o && ship_driver_ctrl_o == 2'h0)
      else $error("ship controls while unfitted");
   a_write_fields: assert property (s_wr14 |=>
      otg_discharge_limit_o == $past(wdata_i[4:3]) &&
      batt_current_out_en_o == $past(wdata_i[5]) &&
      ship_switch_fitted_o == $past(wdata_i[7]))
      else $error("control five write not taken");
   a_rsvd_zero: assert property (s_rd(8'h15) |=> rvalid_o &&
      rdata_o == 8'h00) else $error("reserved register not zero");
   a_temp_bit0: assert property (s_rd(8'h16) |=> rvalid_o &&
      !rdata_o[0]) else $error("temperature bit 0 not zero");
   a_regrst_ctrl5: assert property (reg_reset_i |=>
      {ship_switch_fitted_o, 1'b0, batt_current_out_en_o,
      otg_discharge_limit_o, internal_input_limit_en_o,
      pin_input_limit_en_o, batt_discharge_ocp_en_o} == 8'h16 &&
      !ship_switch_force_off_o) else $error("control five reset wrong");
   a_regrst_temp: assert property (reg_reset_i |=>
      {thermal_reg_threshold_o, thermal_shutdown_threshold_o,
      bus_pulldown_en_o} == 5'h18) else $error("temperature reset wrong");
   a_wdog_restore: assert property (s_wd |=>
      !batt_current_out_en_o && otg_discharge_limit_o == 2'h2 &&
      internal_input_limit_en_o && !batt_discharge_ocp_en_o &&
      thermal_reg_threshold_o == 2'h3 &&
      thermal_shutdown_threshold_o == 2'h0)
      else $error("watchdog fields not restored");
   a_wdog_keep: assert property (s_wd |=>
      $stable(pin_input_limit_en_o) && $stable(bus_pulldown_en_o) &&
      $stable(ship_switch_fitted_o)) else $error("watchdog hit kept field");
endmodule // chgc5_regs_chk

bind chgc5_regs chgc5_regs_chk u_chk (.core_clk_i, .rst_n_i, .wr_en_i,
   .rd_en_i, .rvalid_o, .wdog_expire_i, .reg_reset_i, .ship_switch_fitted_o,
   .ship_switch_force_off_o, .batt_current_out_en_o,
   .internal_input_limit_en_o, .pin_input_limit_en_o,
   .batt_discharge_ocp_en_o, .bus_pulldown_en_o, .addr_i, .wdata_i,
   .rdata_o, .ship_driver_ctrl_o, .otg_discharge_limit_o,
   .thermal_reg_threshold_o, .thermal_shutdown_threshold_o);

// >>> bench/chgc5_host.sv
// host model issuing single-byte register writes and reads
// drives its strobes by non-blocking assignment at the rising edge
`timescale 1ns/10ps
module chgc5_host (
   input  wire       core_clk_i,
   input  wire       rvalid_o,
   input  wire [7:0] rdata_o,
   output reg        wr_en_i = 1'b0,
   output reg        rd_en_i = 1'b0,
   output reg  [7:0] addr_i = 8'h00,
   output reg  [7:0] wdata_i = 8'h00
);
   task wr(input [7:0] a, input [7:0] d);
      @(posedge core_clk_i);
      {wr_en_i, addr_i, wdata_i} <= {1'b1, a, d};
      @(posedge core_clk_i);
      wr_en_i <= 1'b0;
   endtask
   // bounded wait: to is set when no answer came
   task rd(input [7:0] a, output [7:0] d, output to);
      integer n;
      @(posedge core_clk_i);
      {rd_en_i, addr_i} <= {1'b1, a};
      @(posedge core_clk_i);
      rd_en_i <= 1'b0;
      #1;
      for (n = 0; rvalid_o !== 1'b1 && n < 4; n = n + 1) begin
         @(posedge core_clk_i);
         #1;
      end
      d = rdata_o;
      to = (n == 4);
   endtask
   // this board carries a ship switch, so the fitted bit goes to 1
   task board_cfg; wr(8'h14, 8'h96); endtask
endmodule // chgc5_host

// >>> bench/chgc5_regs_tb.sv
// self-checking bench for the charger control five register block
// the host model makes the register accesses; the checker is bound in
`timescale 1ns/10ps
module chgc5_regs_tb;
   reg        core_clk_i = 1'b0, rst_n_i = 1'b0, force_off_i = 1'b1;
   reg        wdog_expire_i = 1'b0, reg_reset_i = 1'b0, force_off_wr_i = 1'b1;
   reg  [1:0] drv_ctrl_wr_i = 2'h3;
   wire       wr_en_i, rd_en_i, rvalid_o, ship_switch_fitted_o;
   wire       ship_switch_force_off_o, batt_current_out_en_o;
   wire       internal_input_limit_en_o, pin_input_limit_en_o;
   wire       batt_discharge_ocp_en_o, bus_pulldown_en_o;
   wire       source1_pulldown_en_o, source2_pulldown_en_o;
   wire [7:0] addr_i, wdata_i, rdata_o;
   wire [1:0] ship_driver_ctrl_o, otg_discharge_limit_o;
   wire [1:0] thermal_reg_threshold_o, thermal_shutdown_threshold_o;
   integer    mismatches = 0, n_compared = 0;
   reg  [2:0] c;
   wire [7:0] ctrl5_pins = {ship_switch_fitted_o, 1'b0, batt_current_out_en_o,
      otg_discharge_limit_o, internal_input_limit_en_o, pin_input_limit_en_o,
      batt_discharge_ocp_en_o};
   wire [7:0] temp_pins = {thermal_reg_threshold_o,
      thermal_shutdown_threshold_o, bus_pulldown_en_o, source1_pulldown_en_o,
      source2_pulldown_en_o, 1'b0};
   always #2.5 core_clk_i = ~core_clk_i;
   chgc5_host h (.core_clk_i, .rvalid_o, .rdata_o, .wr_en_i, .rd_en_i,
      .addr_i, .wdata_i);
   chgc5_regs dut (.core_clk_i, .rst_n_i, .wr_en_i, .rd_en_i, .addr_i,
      .wdata_i, .rdata_o, .rvalid_o, .wdog_expire_i, .reg_reset_i,
      .force_off_wr_i, .force_off_i, .drv_ctrl_wr_i, .ship_switch_fitted_o,
      .ship_switch_force_off_o, .ship_driver_ctrl_o, .batt_current_out_en_o,
      .otg_discharge_limit_o, .internal_input_limit_en_o,
      .pin_input_limit_en_o, .batt_discharge_ocp_en_o,
      .thermal_reg_threshold_o, .thermal_shutdown_threshold_o,
      .bus_pulldown_en_o, .source1_pulldown_en_o, .source2_pulldown_en_o);
   task chk(input string n, input [7:0] e, input [7:0] s);
      n_compared = n_compared + 1;
      if (s !== e) begin
         mismatches = mismatches + 1;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task rdc(input [7:0] a, input [7:0] e);
      reg [7:0] d;
      reg       to;
      h.rd(a, d, to);
      if (to) begin
         mismatches = mismatches + 1;
         wrap_up;
      end else
         chk("rdata", e, d);
   endtask
   task pulse(input w);
      @(posedge core_clk_i);
      {wdog_expire_i, reg_reset_i} <= {w, !w};
      @(posedge core_clk_i);
      {wdog_expire_i, reg_reset_i} <= 2'h0;
   endtask
   initial begin
      repeat (8) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      rdc(8'h14, 8'h16);
      rdc(8'h15, 8'h00);
      rdc(8'h16, 8'hc0);
      rdc(8'h20, 8'h00);
      h.wr(8'h14, 8'h7f);
      rdc(8'h14, 8'h3e);
      chk("ship", 8'h00, {ship_switch_force_off_o, ship_driver_ctrl_o});
      h.board_cfg;
      h.wr(8'h14, 8'hff);
      rdc(8'h14, 8'hbf);
      chk("ctrl5", 8'hbf, ctrl5_pins);
      chk("ship", 8'h07, {ship_switch_force_off_o, ship_driver_ctrl_o});
      @(posedge core_clk_i);
      {force_off_i, drv_ctrl_wr_i} <= 3'h1;
      repeat (2) @(posedge core_clk_i);
      #1 chk("ship", 8'h01, {ship_switch_force_off_o, ship_driver_ctrl_o});
      for (c = 0; c < 4; c = c + 1) begin
         h.wr(8'h14, 8'ha1 | (c << 3));
         rdc(8'h14, 8'ha1 | (c << 3));
         chk("otg", c, {6'h0, otg_discharge_limit_o});
      end
      h.wr(8'h15, 8'hff);
      rdc(8'h15, 8'h00);
      h.wr(8'h16, 8'h3f);
      rdc(8'h16, 8'h3e);
      chk("temp", 8'h3e, temp_pins);
      pulse(1'b1);
      rdc(8'h14, 8'h94);
      rdc(8'h16, 8'hce);
      chk("temp", 8'hce, temp_pins);
      chk("ctrl5", 8'h94, ctrl5_pins);
      fork
         h.wr(8'h16, 8'h00);
         pulse(1'b0);
      join
      rdc(8'h16, 8'hc0);
      rdc(8'h14, 8'h16);
      chk("ship", 8'h00, {ship_switch_force_off_o, ship_driver_ctrl_o});
      wrap_up;
   end
endmodule // chgc5_regs_tb
